/* File: hdl/ptm_pkg.sv */
// shared constants and types for the privilege and translation control block
package ptm_pkg;
	// address and entry field widths
	localparam int OFF_W = 10;
	localparam int PID_W = 8;
	localparam int SIZE_W = 3;
	localparam int ZSEL_W = 4;
	localparam int APB_AW = 8;
	localparam int TLB_DEPTH = 64;
	localparam int MSR_W = 5;
	localparam int CTRL_W = 4;
	// register byte offsets
	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_MSR = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_PID = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_ZPR = 8'h0c;
	localparam logic [APB_AW-1:0] ADDR_TLBX = 8'h10;
	localparam logic [APB_AW-1:0] ADDR_TLBHI = 8'h14;
	localparam logic [APB_AW-1:0] ADDR_TLBLO = 8'h18;
	localparam logic [APB_AW-1:0] ADDR_RPNX = 8'h1c;
	localparam logic [APB_AW-1:0] ADDR_CAUSE = 8'h20;
	// machine status bits
	localparam int MSR_UM = 0;
	localparam int MSR_VM = 1;
	localparam int MSR_UMS = 2;
	localparam int MSR_VMS = 3;
	localparam int MSR_CARRY = 4;
	localparam logic [MSR_W-1:0] MSR_RST = 5'h00;
	localparam logic [MSR_W-1:0] MSR_CARRY_ONLY = 5'h10;
	localparam logic [MSR_W-1:0] MSR_NO_VIRT = 5'h15;
	// control bits: translation and protection per side
	localparam int CTRL_IX = 0;
	localparam int CTRL_DX = 1;
	localparam int CTRL_IP = 2;
	localparam int CTRL_DP = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'hf;
	// translation entry layout in the fill registers
	localparam int HI_TAG_LSB = 10;
	localparam int HI_SIZE_LSB = 7;
	localparam int HI_VALID = 6;
	localparam int LO_EX = 9;
	localparam int LO_WR = 8;
	localparam int LO_ZSEL_LSB = 4;
	// vector offsets from the vector base
	localparam logic [31:0] VEC_SYSCALL = 32'h0000_0008;
	localparam logic [31:0] VEC_BREAK = 32'h0000_0018;
	typedef enum logic [3:0] {
		IC_NONE = 4'h0, IC_STREAM = 4'h1, IC_CACHE_WR = 4'h2, IC_SPR_WR = 4'h3,
		IC_MSR_SET = 4'h4, IC_MSR_CLR = 4'h5, IC_BRK = 4'h6, IC_BREAK_IMMEDIATE_INSTR = 4'h7,
		IC_RETURN = 4'h8, IC_SLEEP = 4'h9, IC_EXT_LDST = 4'ha, IC_ABS_LINK_BRANCH_DELAYED_INSTR = 4'hb
	} ptm_iclass_t;
	typedef enum logic [2:0] {
		CS_NONE = 3'h0, CS_PRIV = 3'h1, CS_SYSCALL = 3'h2, CS_IMISS = 3'h3,
		CS_DMISS = 3'h4, CS_IPROT = 3'h5, CS_DPROT = 3'h6
	} ptm_cause_t;
endpackage

/* File: hdl/ptm_tlb_if.sv */
// lookup and fill signals between mode control and the translation buffer
`timescale 1ns/1ps
interface ptm_tlb_if #(
	parameter int EA_W = 32,
	parameter int PA_W = 32,
	parameter int IDX_W = 6
);
	logic fillEn;
	logic [IDX_W-1:0] fillIdx;
	logic [31:0] fillHi;
	logic [31:0] fillLo;
	logic [PA_W-ptm_pkg::OFF_W-1:0] fillRpn;
	logic [ptm_pkg::PID_W-1:0] process_identifier;
	logic [EA_W-1:0] iEa;
	logic [EA_W-1:0] dEa;
	logic iHit, iEx, dHit, dWr;
	logic [ptm_pkg::ZSEL_W-1:0] iZsel;
	logic [ptm_pkg::ZSEL_W-1:0] dZsel;
	logic [PA_W-1:0] iPa;
	logic [PA_W-1:0] dPa;
	modport core (output fillEn, fillIdx, fillHi, fillLo, fillRpn, process_identifier, iEa, dEa,
		input iHit, iEx, iZsel, iPa, dHit, dWr, dZsel, dPa);
	modport tlb (input fillEn, fillIdx, fillHi, fillLo, fillRpn, process_identifier, iEa, dEa,
		output iHit, iEx, iZsel, iPa, dHit, dWr, dZsel, dPa);
endinterface

/* File: hdl/ptm_tlb.sv */
// translation buffer: entry storage, fill port and two parallel lookups
`timescale 1ns/1ps
module ptm_tlb #(
	parameter int EA_W = 32,
	parameter int PA_W = 32,
	parameter int ENTRIES = ptm_pkg::TLB_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// lookup and fill
	ptm_tlb_if.tlb bus
);
	import ptm_pkg::*;
	localparam int PW = EA_W - OFF_W;
	localparam int RW = PA_W - OFF_W;
	localparam int RES_W = 3 + ZSEL_W + PA_W;

	if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) $error("entries not a power of two");

	typedef struct packed {
		logic valid;
		logic [SIZE_W-1:0] size;
		logic [PW-1:0] tag;
		logic [PID_W-1:0] tid;
		logic [RW-1:0] rpn;
		logic ex;
		logic wr;
		logic [ZSEL_W-1:0] zsel;
	} ptm_ent_t;

	ptm_ent_t entry [ENTRIES];
	logic [RES_W-1:0] iRes;
	logic [RES_W-1:0] dRes;

	// each size step moves two page-number bits into the offset
	function automatic logic [RW-1:0] sizeMask(input logic [SIZE_W-1:0] size);
		sizeMask = ~({RW{1'b1}} << {size, 1'b0});
	endfunction

	// lowest matching index wins, so overlapping entries resolve predictably
	function automatic logic [RES_W-1:0] lookup(input logic [EA_W-1:0] ea,
		input logic [PID_W-1:0] process_identifier);
		logic [RW-1:0] pn;
		logic [RW-1:0] m;
		logic [RW-1:0] page;
		lookup = '0;
		m = '0;
		page = '0;
		pn = RW'(ea[EA_W-1:OFF_W]);
		for (int k = ENTRIES - 1; k >= 0; k--) begin
			m = sizeMask(entry[k].size);
			if (entry[k].valid && (((RW'(entry[k].tag) ^ pn) & ~m) == '0) &&
				(entry[k].tid == process_identifier || entry[k].tid == '0)) begin
				page = (entry[k].rpn & ~m) | (pn & m);
				lookup = {1'b1, entry[k].ex, entry[k].wr, entry[k].zsel, page, ea[OFF_W-1:0]};
			end
		end
	endfunction

	always_comb begin
		iRes = lookup(bus.iEa, bus.process_identifier);
		dRes = lookup(bus.dEa, bus.process_identifier);
	end

	assign {bus.iHit, bus.iEx} = iRes[RES_W-1 -: 2];
	assign {bus.iZsel, bus.iPa} = iRes[ZSEL_W+PA_W-1:0];
	assign bus.dHit = dRes[RES_W-1];
	assign {bus.dWr, bus.dZsel, bus.dPa} = dRes[ZSEL_W+PA_W:0];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int k = 0; k < ENTRIES; k++) begin
				entry[k].valid <= 1'b0;
			end
		end else if (bus.fillEn) begin
			entry[bus.fillIdx] <= '{valid: bus.fillHi[HI_VALID],
				size: bus.fillHi[HI_SIZE_LSB +: SIZE_W],
				tag: PW'(bus.fillHi[31:HI_TAG_LSB]), tid: bus.process_identifier, rpn: bus.fillRpn,
				ex: bus.fillLo[LO_EX], wr: bus.fillLo[LO_WR],
				zsel: bus.fillLo[LO_ZSEL_LSB +: ZSEL_W]};
		end
	end
endmodule // ptm_tlb

/* File: hdl/ptm_priv_xlate.sv */
// privilege checking, user and virtual mode control and address translation
// Contract
// - user mode privileged instruction raises exception
// - option 1 or 3 frees stream instructions
// - option 2 or 3 frees extended, bypasses translation
// - status set/clear carry-only allowed in user
// - break immediate to base+8/+0x18 allowed
// - listed events leave user and virtual mode
// - exits except reset save prior modes
// - link branch or break to base+8 is syscall
// - real mode physical equals effective address
// - reset starts in real mode
// - virtual-mode bit selects real or virtual
// - level 2 gives protection without translation
// - virtual needs level 3, fast target
// - eight page sizes, freely mixed
// - virtual page is process id plus page
// - offset passes untranslated, split by size
// - search buffer only, hit gives physical page
// - instruction and data sides controlled separately, zones
// - effective address width set by parameter
// - physical address may reach 64 bits
// - protection down to 1 KB pages
// - buffer holds 64 entries
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ptm_priv_xlate #(
	parameter int EA_W = 32,
	parameter int PA_W = 32,
	parameter int TLB_ENTRIES = ptm_pkg::TLB_DEPTH,
	parameter int UNPRIV_OPT = 0,
	parameter int MM_LEVEL = 3,
	parameter int AREA_TARGET = 0,
	parameter logic [63:0] VEC_BASE = 64'h0000_0000_0000_0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register bus
	input wire logic [ptm_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// executing instruction
	input wire logic instValid,
	input wire ptm_pkg::ptm_iclass_t instClass,
	input wire logic [EA_W-1:0] instOperand,
	// mode exit events
	input wire logic dbgReset,
	input wire logic hwException,
	input wire logic nmiBreak,
	input wire logic interrupt,
	// instruction side address
	input wire logic iReq,
	input wire logic [EA_W-1:0] iEa,
	output logic iPaValid,
	output logic [PA_W-1:0] iPa,
	output logic iMiss,
	output logic iProtFault,
	// data side address
	input wire logic dReq,
	input wire logic dWrite,
	input wire logic dExt,
	input wire logic [EA_W-1:0] dEa,
	output logic dPaValid,
	output logic [PA_W-1:0] dPa,
	output logic dMiss,
	output logic dProtFault,
	// exceptions and mode
	output logic privExc,
	output logic syscallExc,
	output logic userMode,
	output logic virtMode
);
	import ptm_pkg::*;
	localparam int IDX_W = $clog2(TLB_ENTRIES);
	localparam int RW = PA_W - OFF_W;
	localparam bit AREA_OK = (AREA_TARGET == 0) || (AREA_TARGET == 2);
	localparam bit VIRT_OK = (MM_LEVEL == 3) && AREA_OK;
	localparam bit PROT_OK = (MM_LEVEL > 1) && AREA_OK;
	localparam bit STREAM_FREE = (UNPRIV_OPT == 1) || (UNPRIV_OPT == 3);
	localparam bit EXT_FREE = (UNPRIV_OPT == 2) || (UNPRIV_OPT == 3);
	localparam logic [MSR_W-1:0] MSR_IMPL = VIRT_OK ? {MSR_W{1'b1}} : MSR_NO_VIRT;
	localparam logic [EA_W-1:0] VEC_SYS = VEC_BASE[EA_W-1:0] + EA_W'(VEC_SYSCALL);
	localparam logic [EA_W-1:0] VEC_BRK = VEC_BASE[EA_W-1:0] + EA_W'(VEC_BREAK);

	// 32-bit core uses 32, the 64-bit core up to 64
	if (EA_W < 32 || EA_W > 64 || PA_W < EA_W || PA_W > 64) $error("bad address width");
	if (UNPRIV_OPT > 3 || MM_LEVEL > 3 || TLB_ENTRIES != 2 ** IDX_W) $error("bad option");

	logic [CTRL_W-1:0] ctrl;
	logic [MSR_W-1:0] machine_status_reg;
	logic [MSR_W-1:0] next_msr;
	logic [PID_W-1:0] process_identifier;
	logic [31:0] zpr;
	logic [IDX_W-1:0] tlbIdx;
	logic [31:0] tlbHi;
	logic [31:0] rpnExt;
	ptm_cause_t cause;
	logic um, vm;
	logic privHit, sysCall, brkExit, modeExit, retOk;
	logic apbDone, apbWr, mapped;
	logic iXlate, iProt, dXlate, dProt, dBypass;
	logic iMissNow, iFaultNow, dMissNow, dFaultNow;

	ptm_tlb_if #(.EA_W(EA_W), .PA_W(PA_W), .IDX_W(IDX_W)) tlbBus ();

	ptm_tlb #(.EA_W(EA_W), .PA_W(PA_W), .ENTRIES(TLB_ENTRIES)) u_tlb (
		.clk(clk),
		.rstn(rstn),
		.bus(tlbBus)
	);

	assign um = machine_status_reg[MSR_UM];
	assign vm = machine_status_reg[MSR_VM];

	function automatic logic needsPriv(input ptm_iclass_t cls, input logic [EA_W-1:0] op);
		needsPriv = 1'b0;
		unique case (cls)
			IC_STREAM: needsPriv = !STREAM_FREE;
			IC_EXT_LDST: needsPriv = !EXT_FREE;
			IC_MSR_SET, IC_MSR_CLR: needsPriv = (op[MSR_W-1:0] & ~MSR_CARRY_ONLY) != '0;
			IC_BREAK_IMMEDIATE_INSTR: needsPriv = !(op == VEC_SYS || op == VEC_BRK);
			IC_CACHE_WR, IC_SPR_WR, IC_BRK, IC_RETURN, IC_SLEEP: needsPriv = 1'b1;
			IC_NONE, IC_ABS_LINK_BRANCH_DELAYED_INSTR: needsPriv = 1'b0;
		endcase
	endfunction

	// zone 00 shuts user code out, 11 opens the page, others follow the entry
	function automatic logic zoneOk(input logic [ZSEL_W-1:0] zsel, input logic user,
		input logic perm);
		logic [1:0] zone;
		zoneOk = 1'b0;
		zone = zpr[{zsel, 1'b0} +: 2];
		unique case (zone)
			2'b00: zoneOk = !user;
			2'b11: zoneOk = 1'b1;
			2'b01, 2'b10: zoneOk = perm;
		endcase
	endfunction

	// byte strobes keep unwritten lanes
	function automatic logic [31:0] wmerge(input logic [31:0] old);
		for (int b = 0; b < 4; b++) begin
			wmerge[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : old[8*b +: 8];
		end
	endfunction

	function automatic logic [31:0] regRead(input logic [APB_AW-1:0] addr);
		regRead = '0;
		unique case (addr)
			ADDR_CTRL: regRead = 32'(ctrl);
			ADDR_MSR: regRead = 32'(machine_status_reg);
			ADDR_PID: regRead = 32'(process_identifier);
			ADDR_ZPR: regRead = zpr;
			ADDR_TLBX: regRead = 32'(tlbIdx);
			ADDR_TLBHI: regRead = tlbHi;
			ADDR_RPNX: regRead = rpnExt;
			ADDR_CAUSE: regRead = 32'(cause);
			default: regRead = '0;
		endcase
	endfunction

	// instruction classification and mode exits
	always_comb begin
		privHit = instValid && um && needsPriv(instClass, instOperand);
		sysCall = instValid && !privHit && instOperand == VEC_SYS &&
			(instClass == IC_ABS_LINK_BRANCH_DELAYED_INSTR || instClass == IC_BREAK_IMMEDIATE_INSTR);
		brkExit = instValid && !privHit && instClass == IC_BREAK_IMMEDIATE_INSTR && instOperand == VEC_BRK;
		modeExit = hwException || nmiBreak || interrupt || privHit || sysCall || brkExit;
		retOk = instValid && !um && instClass == IC_RETURN;
	end

	// hardware events outrank software writes of the status bits
	always_comb begin
		next_msr = machine_status_reg;
		if (dbgReset) begin
			next_msr[MSR_UM] = 1'b0;
			next_msr[MSR_VM] = 1'b0;
		end else if (modeExit) begin
			next_msr[MSR_UMS] = machine_status_reg[MSR_UM];
			next_msr[MSR_VMS] = machine_status_reg[MSR_VM];
			next_msr[MSR_UM] = 1'b0;
			next_msr[MSR_VM] = 1'b0;
		end else if (retOk) begin
			next_msr[MSR_UM] = machine_status_reg[MSR_UMS];
			next_msr[MSR_VM] = machine_status_reg[MSR_VMS];
		end else if (instValid && instClass == IC_MSR_SET) begin
			next_msr = machine_status_reg | instOperand[MSR_W-1:0];
		end else if (instValid && instClass == IC_MSR_CLR) begin
			next_msr = machine_status_reg & ~instOperand[MSR_W-1:0];
		end else if (apbWr && paddr == ADDR_MSR) begin
			next_msr = MSR_W'(wmerge(32'(machine_status_reg)));
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			machine_status_reg <= MSR_RST;
		end else begin
			machine_status_reg <= next_msr & MSR_IMPL;
		end
	end

	// two-cycle access: pready rises one cycle into the access phase
	assign apbDone = psel && penable && pready;
	assign apbWr = apbDone && pwrite;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_CAUSE);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= (psel && penable && !pready && !pwrite) ? regRead(paddr) : '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl <= CTRL_RST;
			process_identifier <= '0;
			zpr <= '0;
			tlbIdx <= '0;
			tlbHi <= '0;
			rpnExt <= '0;
		end else if (apbWr) begin
			if (paddr == ADDR_CTRL) begin
				ctrl <= CTRL_W'(wmerge(32'(ctrl)));
			end
			if (paddr == ADDR_PID) begin
				process_identifier <= PID_W'(wmerge(32'(process_identifier)));
			end
			if (paddr == ADDR_ZPR) begin
				zpr <= wmerge(zpr);
			end
			if (paddr == ADDR_TLBX) begin
				tlbIdx <= IDX_W'(wmerge(32'(tlbIdx)));
			end
			if (paddr == ADDR_TLBHI) begin
				tlbHi <= wmerge(tlbHi);
			end
			if (paddr == ADDR_RPNX) begin
				rpnExt <= wmerge(rpnExt);
			end
		end
	end

	// writing the low half commits the staged entry
	assign tlbBus.fillEn = apbWr && paddr == ADDR_TLBLO;
	assign tlbBus.fillIdx = tlbIdx;
	assign tlbBus.fillHi = tlbHi;
	assign tlbBus.fillLo = pwdata;
	assign tlbBus.fillRpn = RW'({rpnExt, pwdata[31:OFF_W]});
	assign tlbBus.process_identifier = process_identifier;
	assign tlbBus.iEa = iEa;
	assign tlbBus.dEa = dEa;

	// per-side translation and protection steering
	always_comb begin
		dBypass = dExt && EXT_FREE;
		iXlate = VIRT_OK && vm && ctrl[CTRL_IX];
		dXlate = VIRT_OK && vm && ctrl[CTRL_DX] && !dBypass;
		iProt = PROT_OK && um && ctrl[CTRL_IP];
		dProt = PROT_OK && um && ctrl[CTRL_DP] && !dBypass;
		iMissNow = iReq && (iXlate || iProt) && !tlbBus.iHit;
		dMissNow = dReq && (dXlate || dProt) && !tlbBus.dHit;
		iFaultNow = iReq && (iXlate || iProt) && tlbBus.iHit &&
			!zoneOk(tlbBus.iZsel, um, tlbBus.iEx);
		dFaultNow = dReq && (dXlate || dProt) && tlbBus.dHit &&
			!zoneOk(tlbBus.dZsel, um, !dWrite || tlbBus.dWr);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			iPaValid <= 1'b0;
			iPa <= '0;
			iMiss <= 1'b0;
			iProtFault <= 1'b0;
		end else begin
			iPaValid <= iReq && !iMissNow && !iFaultNow;
			iPa <= iXlate ? tlbBus.iPa : PA_W'(iEa);
			iMiss <= iMissNow;
			iProtFault <= iFaultNow;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dPaValid <= 1'b0;
			dPa <= '0;
			dMiss <= 1'b0;
			dProtFault <= 1'b0;
		end else begin
			dPaValid <= dReq && !dMissNow && !dFaultNow;
			dPa <= dXlate ? tlbBus.dPa : PA_W'(dEa);
			dMiss <= dMissNow;
			dProtFault <= dFaultNow;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			privExc <= 1'b0;
			syscallExc <= 1'b0;
			userMode <= 1'b0;
			virtMode <= 1'b0;
		end else begin
			privExc <= privHit;
			syscallExc <= sysCall;
			userMode <= next_msr[MSR_UM];
			virtMode <= next_msr[MSR_VM] && VIRT_OK;
		end
	end

	// most recent cause, kept until the next one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cause <= CS_NONE;
		end else if (privHit) begin
			cause <= CS_PRIV;
		end else if (sysCall) begin
			cause <= CS_SYSCALL;
		end else if (iMissNow) begin
			cause <= CS_IMISS;
		end else if (dMissNow) begin
			cause <= CS_DMISS;
		end else if (iFaultNow) begin
			cause <= CS_IPROT;
		end else if (dFaultNow) begin
			cause <= CS_DPROT;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_priv_user_trap: assert property (
		instValid && um && instClass == IC_CACHE_WR && !dbgReset
		|=> privExc && !machine_status_reg[MSR_UM] && machine_status_reg[MSR_UMS] && cause == CS_PRIV)
		else $error("privileged instruction in user mode not trapped");
	a_stream_option: assert property (
		instValid && instClass == IC_STREAM |=> privExc == (!STREAM_FREE && $past(um)))
		else $error("stream instruction privilege wrong");
	a_ext_bypass: assert property (
		EXT_FREE && dReq && dExt |=> dPaValid && !dMiss && dPa == PA_W'($past(dEa)))
		else $error("extended access not passed through");
	a_carry_only: assert property (
		instValid && um && instClass == IC_MSR_SET && instOperand[MSR_W-1:0] == MSR_CARRY_ONLY
		&& !(hwException || nmiBreak || interrupt || dbgReset)
		|=> !privExc && machine_status_reg[MSR_CARRY] && machine_status_reg[MSR_UM])
		else $error("carry-only status set refused");
	a_break_immediate_instr_target: assert property (
		instValid && um && instClass == IC_BREAK_IMMEDIATE_INSTR && instOperand == VEC_BRK && !dbgReset
		|=> !privExc && !syscallExc && machine_status_reg[MSR_UMS] && !machine_status_reg[MSR_UM])
		else $error("break to allowed target mishandled");
	a_exit_saves: assert property (
		interrupt && !dbgReset |=> machine_status_reg[MSR_UMS] == $past(um) && machine_status_reg[MSR_VMS] == $past(vm)
		&& !machine_status_reg[MSR_UM] && !machine_status_reg[MSR_VM] && !userMode ##1 !virtMode || um)
		else $error("mode exit did not save and clear");
	a_syscall_vec: assert property (
		instValid && instClass == IC_ABS_LINK_BRANCH_DELAYED_INSTR && instOperand == VEC_SYS
		|=> syscallExc && cause == CS_SYSCALL)
		else $error("system call not raised");
	a_real_identity: assert property (
		iReq && !vm && !iProt |=> iPaValid && iPa == PA_W'($past(iEa)))
		else $error("real mode address altered");
	a_reset_real: assert property (
		$rose(rstn) |-> !vm && !um && !virtMode)
		else $error("not in real mode after reset");
	a_no_virt: assert property (
		!VIRT_OK |-> !vm && !virtMode)
		else $error("virtual mode without translation level");
	a_miss_abort: assert property (
		iReq && vm && ctrl[CTRL_IX] && !tlbBus.iHit |=> iMiss && !iPaValid ##1 !iMiss || iReq)
		else $error("translation miss not raised");
endmodule // ptm_priv_xlate

/* File: dv/ptm_priv_xlate_test.sv */
// self-checking bench for the privilege and translation control block
`timescale 1ns/1ps
module ptm_priv_xlate_test;
	import ptm_pkg::*;
	localparam int UO = 1;
	localparam logic [63:0] VB = 64'h0000_0000_0000_1000;
	localparam logic [31:0] SC = 32'h0000_1008;
	localparam logic [31:0] BK = 32'h0000_1018;
	logic clk, rstn, psel, penable, pwrite, instValid, iReq, dReq, dWrite, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, instOperand, iEa, dEa, iPa, dPa, rd, a, b;
	logic [3:0] evt;
	ptm_iclass_t instClass;
	logic pready, pslverr, iPaValid, iMiss, iProtFault, dPaValid, dMiss, dProtFault;
	logic privExc, syscallExc, userMode, virtMode;
	int miscompares, compares, seed, machine_status_reg;
	ptm_iclass_t cl [14] = '{IC_STREAM, IC_CACHE_WR, IC_SPR_WR, IC_MSR_SET, IC_MSR_SET,
		IC_MSR_CLR, IC_BRK, IC_RETURN, IC_SLEEP, IC_EXT_LDST, IC_BREAK_IMMEDIATE_INSTR, IC_BREAK_IMMEDIATE_INSTR, IC_BREAK_IMMEDIATE_INSTR,
		IC_ABS_LINK_BRANCH_DELAYED_INSTR};
	logic [31:0] ops [14] = '{0, 0, 0, 32'h0000_0010, 32'h0000_0002, 32'h0000_0010, 0, 0, 0,
		0, BK, SC, 32'h0000_2000, SC};

	ptm_priv_xlate #(.UNPRIV_OPT(UO), .VEC_BASE(VB)) dut (.clk(clk), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instValid(instValid), .instClass(instClass), .instOperand(instOperand),
		.dbgReset(evt[3]), .hwException(evt[2]), .nmiBreak(evt[1]), .interrupt(evt[0]),
		.iReq(iReq), .iEa(iEa), .iPaValid(iPaValid), .iPa(iPa), .iMiss(iMiss),
		.iProtFault(iProtFault), .dReq(dReq), .dWrite(dWrite), .dExt(1'b0), .dEa(dEa),
		.dPaValid(dPaValid), .dPa(dPa), .dMiss(dMiss), .dProtFault(dProtFault),
		.privExc(privExc), .syscallExc(syscallExc), .userMode(userMode), .virtMode(virtMode));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chkv(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task chkf(input logic g, input logic e);
		chkv({31'h0, g}, {31'h0, e});
	endtask

	// holds the request until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		if (n >= 16) miscompares++;
		{psel, penable} <= 2'b00;
	endtask

	task inst(input ptm_iclass_t c, input logic [31:0] op);
		logic pv, p, s, x;
		case (c)
			IC_STREAM: pv = !(UO == 1 || UO == 3);
			IC_EXT_LDST: pv = !(UO == 2 || UO == 3);
			IC_MSR_SET, IC_MSR_CLR: pv = op[4:0] != MSR_CARRY_ONLY;
			IC_BREAK_IMMEDIATE_INSTR: pv = op != SC && op != BK;
			IC_NONE, IC_ABS_LINK_BRANCH_DELAYED_INSTR: pv = 1'b0;
			default: pv = 1'b1;
		endcase
		p = machine_status_reg[0] && pv;
		s = !p && (c == IC_BREAK_IMMEDIATE_INSTR || c == IC_ABS_LINK_BRANCH_DELAYED_INSTR) && op == SC;
		x = p || s || (c == IC_BREAK_IMMEDIATE_INSTR && !pv);
		if (x) machine_status_reg = (machine_status_reg & 16) | ((machine_status_reg & 3) << 2);
		else if (c == IC_MSR_SET) machine_status_reg = machine_status_reg | op[4:0];
		else if (c == IC_MSR_CLR) machine_status_reg = machine_status_reg & ~int'(op[4:0]);
		@(posedge clk);
		{instValid, instClass, instOperand} <= {1'b1, c, op};
		@(posedge clk);
		instValid <= 1'b0;
		#1;
		chkf(privExc, p);
		chkf(syscallExc, s);
		chkf(userMode, machine_status_reg[0]);
		apb(1'b0, ADDR_MSR, 32'h0);
		chkv(rd, machine_status_reg);
	endtask

	// one lookup on each side; hit flags pick valid or miss
	task xl(input logic [31:0] ia, da, ipa, dpa, input logic ih, dh, w);
		@(posedge clk);
		{iReq, iEa, dReq, dEa, dWrite} <= {1'b1, ia, 1'b1, da, w};
		@(posedge clk);
		{iReq, dReq} <= 2'b00;
		#1;
		chkf(iPaValid, ih);
		chkf(iMiss, !ih);
		chkf(dPaValid, dh);
		chkf(dMiss, !dh);
		if (ih) chkv(iPa, ipa);
		if (dh) chkv(dPa, dpa);
	endtask

	task end_of_test;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// whole run needs well under 2000 cycles
	initial begin
		#200000;
		miscompares++;
		end_of_test;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{instValid, instOperand, iReq, iEa, dReq, dEa, dWrite, evt} = '0;
		instClass = IC_NONE;
		seed = 32'hd5f0df34;
		miscompares = 0;
		compares = 0;
		machine_status_reg = 0;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, ADDR_MSR, 32'h0);
		chkv(rd, 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chkv(rd, {28'h0, CTRL_RST});
		apb(1'b0, 8'h40, 32'h0);
		chkf(er, 1'b1);
		apb(1'b1, 8'h06, 32'h0);
		chkf(er, 1'b1);
		$display("test reset done");
		repeat (20) begin
			a = $random(seed);
			b = $random(seed);
			xl(a, b, a, b, 1'b1, 1'b1, a[0]);
		end
		$display("test real mode done");
		for (int i = 0; i < 14; i++) begin
			apb(1'b1, ADDR_MSR, 32'h1);
			machine_status_reg = 1;
			inst(cl[i], ops[i]);
		end
		$display("test privilege done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, ADDR_MSR, 32'h13);
			machine_status_reg = 19;
			@(posedge clk);
			evt <= 4'h1 << k;
			@(posedge clk);
			evt <= 4'h0;
			#1;
			machine_status_reg = (k == 3) ? 16 : 28;
			chkf(userMode, 1'b0);
			chkf(virtMode, 1'b0);
			apb(1'b0, ADDR_MSR, 32'h0);
			chkv(rd, machine_status_reg);
		end
		$display("test exit events done");
		apb(1'b1, ADDR_PID, 32'h5);
		apb(1'b1, ADDR_TLBX, 32'h0);
		apb(1'b1, ADDR_TLBHI, 32'h0004_0040);
		apb(1'b1, ADDR_TLBLO, 32'h0009_0300);
		apb(1'b1, ADDR_MSR, 32'h2);
		// mode level updates on the completing edge, look once it has settled
		#1;
		chkf(virtMode, 1'b1);
		xl(32'h0004_0123, 32'h0004_03fc, 32'h0009_0123, 32'h0009_03fc, 1'b1, 1'b1, 1'b1);
		xl(32'h0008_0000, 32'h0004_0400, 0, 0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, ADDR_PID, 32'h6);
		xl(32'h0004_0123, 32'h0004_0010, 0, 0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, ADDR_MSR, 32'h0);
		xl(32'h0004_0123, 32'h0004_0010, 32'h0004_0123, 32'h0004_0010, 1'b1, 1'b1, 1'b0);
		// user code in zone 00 is shut out, zone 11 opens the page
		apb(1'b1, ADDR_PID, 32'h5);
		apb(1'b1, ADDR_MSR, 32'h3);
		@(posedge clk);
		{iReq, iEa, dReq, dEa, dWrite} <= {1'b1, 32'h0004_0123, 1'b1, 32'h0004_0010, 1'b1};
		@(posedge clk);
		{iReq, dReq} <= 2'b00;
		#1;
		chkf(iProtFault, 1'b1);
		chkf(dProtFault, 1'b1);
		chkf(iMiss, 1'b0);
		chkf(dPaValid, 1'b0);
		apb(1'b1, ADDR_ZPR, 32'h3);
		xl(32'h0004_0123, 32'h0004_0010, 32'h0009_0123, 32'h0009_0010, 1'b1, 1'b1, 1'b1);
		$display("test virtual mode done");
		end_of_test;
	end
endmodule // ptm_priv_xlate_test
